// >>> core/rsof_fifo.sv
`default_nettype none
// small flip-flop fifo, full and empty from an occupancy count
module rsof_fifo #(
   parameter int unsigned W = 8,
   parameter int unsigned D = 4
) (
   input wire logic clk,
   input wire logic rst,
   rsof_stream_if.snk wr,
   rsof_stream_if.src rd
);
   localparam int unsigned AW = (D > 1) ? $clog2(D) : 1;
   // pointers wrap by overflow, so only powers of two keep the indices aligned
   if (D < 2 || (D & (D - 1)) != 0)
   begin : g_bad_depth
      $error("rsof_fifo: depth must be a power of two >= 2");
   end
   logic [W-1:0] mem_r [D]; // storage
   logic [AW-1:0] wp_r; // write index
   logic [AW-1:0] rp_r; // read index
   logic [AW:0] cnt_r; // occupancy
   logic do_wr;
   logic do_rd;
   assign wr.ready = (cnt_r < (AW + 1)'(D)); // honest full, empty fifo accepts too
   assign rd.valid = (cnt_r != '0); // honest empty
   assign rd.data = mem_r[rp_r];
   assign do_wr = wr.valid && wr.ready;
   assign do_rd = rd.valid && rd.ready;
   // storage write, no reset needed on data
   always_ff @(posedge clk)
   begin
      if (do_wr) mem_r[wp_r] <= wr.data;
   end
   // pointers and count
   always_ff @(posedge clk)
   begin
      if (rst)
      begin
         wp_r <= '0;
         rp_r <= '0;
         cnt_r <= '0;
      end
      else
      begin
         if (do_wr) wp_r <= wp_r + 1'b1;
         if (do_rd) rp_r <= rp_r + 1'b1;
         if (do_wr && !do_rd) cnt_r <= cnt_r + 1'b1;
         else if (do_rd && !do_wr) cnt_r <= cnt_r - 1'b1;
      end
   end
endmodule : rsof_fifo
`default_nettype wire

// >>> core/rsof_pkg.sv
`default_nettype none
package rsof_pkg;
   // system clock and serial character timing
   localparam int unsigned CLK_HZ = 32'h0098_9680;      // 10 MHz core clock
   localparam int unsigned BAUD_DEF = 32'h0001_C200;    // 115200 baud by default
   localparam int unsigned BAUD_DIV = (CLK_HZ + BAUD_DEF / 2) / BAUD_DEF; // cycles per bit
   localparam int unsigned UART_BITS = 10;              // start, 8 data, 1 stop, no parity
   // two-wire timing: oversampling needed to see every scl phase
   localparam int unsigned TWI_MAX_HZ = 32'h0006_1A80;  // 400 kbit/s ceiling
   localparam int unsigned TWI_OVERSAMPLE = 20;         // core cycles per scl period, least
   localparam logic [6:0] TWI_ADDR_DEF = 7'h10;         // slave address when TWI_ADDR is 0
   // binary frame layout
   localparam int unsigned FRAME_LEN = 9;               // bytes per binary frame
   localparam logic [7:0] FRAME_HDR = 8'h59;            // both header bytes
   localparam int unsigned IDX_DIST = 2;                // distance low byte position
   localparam int unsigned IDX_STR = 4;                 // strength low byte position
   localparam int unsigned IDX_TEMP = 6;                // temperature low byte position
   localparam int unsigned IDX_SUM = 8;                 // checksum position
   // ascii string layout
   localparam int unsigned STR_MAX = 8;                 // "655.35" plus cr lf
   localparam logic [7:0] ASC_ZERO = 8'h30;
   localparam logic [7:0] ASC_DOT = 8'h2E;
   localparam logic [7:0] ASC_CR = 8'h0D;
   localparam logic [7:0] ASC_LF = 8'h0A;
   localparam int unsigned FIFO_DEPTH = 4;              // words between framer and uart
   // two-wire slave states, one-hot
   typedef enum logic [5:0]
   {
      TW_IDLE = 6'h01,
      TW_ADDR = 6'h02,
      TW_ACK = 6'h04,
      TW_SEND = 6'h08,
      TW_MACK = 6'h10,
      TW_RECV = 6'h20
   } rsof_twi_e;
endpackage : rsof_pkg
`default_nettype wire

// >>> core/rsof_stream_if.sv
`default_nettype none
// valid/ready byte stream between framer, fifo and uart
interface rsof_stream_if #(parameter int unsigned W = 8);
   logic valid; // word offered
   logic ready; // word accepted when both high
   logic [W-1:0] data;
   modport src (output valid, output data, input ready);
   modport snk (input valid, input data, output ready);
endinterface : rsof_stream_if
`default_nettype wire

// >>> core/rsof_top.sv
// Operation
// [RQ1] serial 115200 baud, 8 data, 1 stop, no parity
// [RQ2] binary frame nine bytes, two 0x59 headers
// [RQ3] bytes 2-3 distance, low byte first
// [RQ4] bytes 4-5 strength, low byte first
// [RQ5] strength carried as full unsigned 16 bits
// [RQ6] bytes 6-7 raw temperature code, low first
// [RQ7] byte 8 is low byte of sum
// [RQ8] binary or string format, selectable by host
// [RQ9] string: metres in ascii, then cr lf
// [RQ10] two-wire slave only, up to 400 kbit/s
// [RQ11] slave address 0x10 default, 0x01-0x7F settable
// [RQ12] master waits about 100 ms before reading
// [RQ13] multi-byte fields sent low byte first
// [RQ14] serial pins double as two-wire lines
// [RQ15] two-wire read returns latest frame, same order
`default_nettype none
module rsof_top #(
   parameter int unsigned BAUD_CYCLES = rsof_pkg::BAUD_DIV, // cycles per serial bit
   parameter int unsigned FIFO_D = rsof_pkg::FIFO_DEPTH
) (
   input wire logic CLK,
   input wire logic SYS_RST,
   input wire logic MEAS_VALID,          // one-cycle pulse, new measurement
   input wire logic [15:0] MEAS_DIST,    // distance in cm
   input wire logic [15:0] MEAS_STRENGTH,
   input wire logic [15:0] MEAS_TEMP,    // raw temperature code
   input wire logic FMT_STRING,          // 1: ascii metres on serial, 0: binary frame; two-wire reads always binary
   input wire logic IF_TWI,              // 1: pins act as two-wire bus
   input wire logic [6:0] TWI_ADDR,      // slave address, 0 falls back to default
   input wire logic RXD_SDA_I,
   output logic RXD_SDA_O,
   output logic RXD_SDA_OE,
   input wire logic TXD_SCL_I,
   output logic TXD_SCL_O,
   output logic TXD_SCL_OE,
   output logic FRAME_BUSY,              // serial frame still going out
   output logic MEAS_DROP                // pulse: measurement arrived while a message was still being pushed
);
   // refused at elaboration: bit timer needs two states, bus edges need oversampling
   if (BAUD_CYCLES < 2)
   begin : g_bad_baud
      $error("rsof_top: baud divider too small");
   end
   if (rsof_pkg::CLK_HZ < rsof_pkg::TWI_OVERSAMPLE * rsof_pkg::TWI_MAX_HZ)
   begin : g_slow_clk
      $error("rsof_top: clock too slow for 400 kbit/s two-wire");
   end

   // 16-bit binary to five bcd digits by shift-and-add-3
   function automatic logic [19:0] bin2bcd(input logic [15:0] v);
      logic [35:0] s;
      s = {20'h0_0000, v};
      for (int i = 0; i < 16; i++)
      begin
         for (int j = 0; j < 5; j++)
         begin
            if (s[16 + 4 * j +: 4] > 4'h4) s[16 + 4 * j +: 4] = s[16 + 4 * j +: 4] + 4'h3;
         end
         s = {s[34:0], 1'b0};
      end
      return s[35:16];
   endfunction : bin2bcd

   // frame image built straight from the inputs
   logic [7:0] frm [rsof_pkg::FRAME_LEN];
   always_comb
   begin
      logic [7:0] sum;
      sum = 8'h00;
      frm[0] = rsof_pkg::FRAME_HDR; // [RQ2]
      frm[1] = rsof_pkg::FRAME_HDR; // [RQ2]
      frm[rsof_pkg::IDX_DIST] = MEAS_DIST[7:0]; // [RQ3] [RQ13]
      frm[rsof_pkg::IDX_DIST + 1] = MEAS_DIST[15:8]; // [RQ3]
      frm[rsof_pkg::IDX_STR] = MEAS_STRENGTH[7:0]; // [RQ4] [RQ5]
      frm[rsof_pkg::IDX_STR + 1] = MEAS_STRENGTH[15:8]; // [RQ4] [RQ5]
      frm[rsof_pkg::IDX_TEMP] = MEAS_TEMP[7:0]; // [RQ6]
      frm[rsof_pkg::IDX_TEMP + 1] = MEAS_TEMP[15:8]; // [RQ6]
      for (int i = 0; i < rsof_pkg::IDX_SUM; i++) sum = sum + frm[i]; // [RQ7]
      frm[rsof_pkg::IDX_SUM] = sum; // [RQ7]
   end

   // ascii image: leading zeros of the metre part dropped, one digit kept
   logic [7:0] str [rsof_pkg::STR_MAX];
   logic [3:0] str_len;
   always_comb
   begin
      logic [19:0] d;
      logic [3:0] k;
      d = bin2bcd(MEAS_DIST);
      k = 4'h0;
      for (int i = 0; i < rsof_pkg::STR_MAX; i++) str[i] = 8'h00;
      if (d[19:16] != 4'h0)
      begin
         str[k[2:0]] = rsof_pkg::ASC_ZERO | {4'h0, d[19:16]}; // [RQ9]
         k = k + 4'h1;
      end
      if (d[19:12] != 8'h00)
      begin
         str[k[2:0]] = rsof_pkg::ASC_ZERO | {4'h0, d[15:12]};
         k = k + 4'h1;
      end
      str[k[2:0]] = rsof_pkg::ASC_ZERO | {4'h0, d[11:8]};
      str[k[2:0] + 3'h1] = rsof_pkg::ASC_DOT;
      str[k[2:0] + 3'h2] = rsof_pkg::ASC_ZERO | {4'h0, d[7:4]};
      str[k[2:0] + 3'h3] = rsof_pkg::ASC_ZERO | {4'h0, d[3:0]};
      str[k[2:0] + 3'h4] = rsof_pkg::ASC_CR; // [RQ9]
      str[k[2:0] + 3'h5] = rsof_pkg::ASC_LF; // [RQ9]
      str_len = k + 4'h6;
   end

   // latched frame and string, plus generator state
   logic [7:0] frame_r [rsof_pkg::FRAME_LEN];
   logic [7:0] str_r [rsof_pkg::STR_MAX];
   logic [3:0] len_r; // bytes in the current serial message
   logic [3:0] gen_idx_r; // next byte to push
   logic gen_act_r; // serial message being pushed
   logic fmt_r; // format frozen per message so bytes never mix

   rsof_stream_if #(.W(8)) push_if ();
   rsof_stream_if #(.W(8)) pop_if ();

   assign push_if.valid = gen_act_r;
   assign push_if.data = fmt_r ? str_r[gen_idx_r[2:0]] : frame_r[gen_idx_r];

   // capture: a new measurement is taken only while no serial message is being pushed into the fifo
   always_ff @(posedge CLK)
   begin
      if (SYS_RST)
      begin
         for (int i = 0; i < rsof_pkg::FRAME_LEN; i++) frame_r[i] <= 8'h00;
         for (int i = 0; i < rsof_pkg::STR_MAX; i++) str_r[i] <= 8'h00;
         len_r <= 4'h0;
         fmt_r <= 1'b0;
         MEAS_DROP <= 1'b0;
      end
      else
      begin
         MEAS_DROP <= MEAS_VALID && gen_act_r;
         if (MEAS_VALID && !gen_act_r)
         begin
            frame_r <= frm; // [RQ15]
            str_r <= str;
            fmt_r <= FMT_STRING; // [RQ8]
            len_r <= FMT_STRING ? str_len : 4'(rsof_pkg::FRAME_LEN); // [RQ2] [RQ8]
         end
      end
   end

   // generator walks the latched message into the fifo, stalls on full
   always_ff @(posedge CLK)
   begin
      if (SYS_RST)
      begin
         gen_act_r <= 1'b0;
         gen_idx_r <= 4'h0;
      end
      else if (!gen_act_r)
      begin
         // two-wire mode only refreshes the image, nothing is pushed
         gen_act_r <= MEAS_VALID && !IF_TWI; // [RQ14]
         gen_idx_r <= 4'h0;
      end
      else if (push_if.ready)
      begin
         gen_idx_r <= gen_idx_r + 4'h1;
         if (gen_idx_r == len_r - 4'h1) gen_act_r <= 1'b0;
      end
   end

   rsof_fifo #(.W(8), .D(FIFO_D)) u_fifo (
      .clk(CLK),
      .rst(SYS_RST),
      .wr(push_if.snk),
      .rd(pop_if.src)
   );

   // uart transmitter: start bit, 8 data lsb first, stop bit
   logic [9:0] tx_sh_r; // shift register, bit 0 on the line
   logic [3:0] tx_bits_r; // bits still to send
   logic [$clog2(BAUD_CYCLES)-1:0] baud_r; // bit timer
   assign pop_if.ready = (tx_bits_r == 4'h0) && !IF_TWI;
   always_ff @(posedge CLK)
   begin
      if (SYS_RST)
      begin
         tx_sh_r <= 10'h3FF;
         tx_bits_r <= 4'h0;
         baud_r <= '0;
      end
      else if (pop_if.valid && pop_if.ready)
      begin
         tx_sh_r <= {1'b1, pop_if.data, 1'b0}; // [RQ1]
         tx_bits_r <= 4'(rsof_pkg::UART_BITS); // [RQ1]
         baud_r <= '0;
      end
      else if (tx_bits_r != 4'h0)
      begin
         if (baud_r == $bits(baud_r)'(BAUD_CYCLES - 1)) // [RQ1]
         begin
            baud_r <= '0;
            tx_sh_r <= {1'b1, tx_sh_r[9:1]};
            tx_bits_r <= tx_bits_r - 4'h1;
         end
         else baud_r <= baud_r + 1'b1;
      end
   end

   // two-flop synchronisers on both pins
   logic [1:0] sda_s_r;
   logic [1:0] scl_s_r;
   logic sda_d_r; // previous synced sda
   logic scl_d_r; // previous synced scl
   always_ff @(posedge CLK)
   begin
      if (SYS_RST)
      begin
         sda_s_r <= 2'h3;
         scl_s_r <= 2'h3;
         sda_d_r <= 1'b1;
         scl_d_r <= 1'b1;
      end
      else
      begin
         sda_s_r <= {sda_s_r[0], RXD_SDA_I};
         scl_s_r <= {scl_s_r[0], TXD_SCL_I};
         sda_d_r <= sda_s_r[1];
         scl_d_r <= scl_s_r[1];
      end
   end
   logic scl_rise;
   logic scl_fall;
   logic bus_start;
   logic bus_stop;
   logic [6:0] my_addr;
   assign scl_rise = scl_s_r[1] && !scl_d_r;
   assign scl_fall = !scl_s_r[1] && scl_d_r;
   assign bus_start = IF_TWI && scl_s_r[1] && scl_d_r && sda_d_r && !sda_s_r[1];
   assign bus_stop = IF_TWI && scl_s_r[1] && scl_d_r && !sda_d_r && sda_s_r[1];
   assign my_addr = (TWI_ADDR == 7'h00) ? rsof_pkg::TWI_ADDR_DEF : TWI_ADDR; // [RQ11]

   // two-wire slave: samples on scl rise, changes sda on scl fall
   rsof_pkg::rsof_twi_e tw_r;
   logic [7:0] tw_sh_r; // receive or transmit shifter
   logic [2:0] tw_cnt_r; // bit within byte
   logic tw_got8_r; // eighth bit seen
   logic tw_rd_r; // read transfer
   logic tw_nack_r; // master refused the byte
   logic [3:0] tw_idx_r; // next frame byte to send
   logic [7:0] snap_r [rsof_pkg::FRAME_LEN]; // frame frozen for one read
   logic sda_low_r; // pulling sda low
   always_ff @(posedge CLK)
   begin
      if (SYS_RST || !IF_TWI || bus_stop)
      begin
         tw_r <= rsof_pkg::TW_IDLE;
         sda_low_r <= 1'b0;
         tw_cnt_r <= 3'h0;
         tw_got8_r <= 1'b0;
         tw_sh_r <= 8'h00;
         tw_rd_r <= 1'b0;
         tw_nack_r <= 1'b0;
         tw_idx_r <= 4'h0;
      end
      else if (bus_start) // also covers repeated start
      begin
         tw_r <= rsof_pkg::TW_ADDR; // [RQ10]
         sda_low_r <= 1'b0;
         tw_cnt_r <= 3'h0;
         tw_got8_r <= 1'b0;
      end
      else if (scl_rise)
      begin
         if (tw_r == rsof_pkg::TW_MACK) tw_nack_r <= sda_s_r[1];
         else if (tw_r != rsof_pkg::TW_IDLE && tw_r != rsof_pkg::TW_ACK)
         begin
            if (tw_r != rsof_pkg::TW_SEND) tw_sh_r <= {tw_sh_r[6:0], sda_s_r[1]};
            tw_cnt_r <= tw_cnt_r + 3'h1;
            tw_got8_r <= (tw_cnt_r == 3'h7);
         end
      end
      else if (scl_fall)
      begin
         case (tw_r)
            rsof_pkg::TW_ADDR, rsof_pkg::TW_RECV:
            begin
               if (tw_got8_r)
               begin
                  tw_got8_r <= 1'b0;
                  if (tw_r == rsof_pkg::TW_RECV || tw_sh_r[7:1] == my_addr) // [RQ11]
                  begin
                     sda_low_r <= 1'b1; // acknowledge
                     tw_r <= rsof_pkg::TW_ACK;
                     if (tw_r == rsof_pkg::TW_ADDR)
                     begin
                        tw_rd_r <= tw_sh_r[0];
                        tw_idx_r <= 4'h0;
                        snap_r <= frame_r; // [RQ15]
                     end
                  end
                  else tw_r <= rsof_pkg::TW_IDLE; // not ours
               end
            end
            rsof_pkg::TW_ACK, rsof_pkg::TW_MACK:
            begin
               if (tw_rd_r && !(tw_r == rsof_pkg::TW_MACK && tw_nack_r))
               begin
                  tw_sh_r <= {snap_r[tw_idx_r][6:0], 1'b0}; // [RQ15] [RQ13]
                  sda_low_r <= !snap_r[tw_idx_r][7];
                  tw_idx_r <= (tw_idx_r == 4'(rsof_pkg::FRAME_LEN - 1)) ? 4'h0 : tw_idx_r + 4'h1;
                  tw_r <= rsof_pkg::TW_SEND;
               end
               else
               begin
                  sda_low_r <= 1'b0;
                  tw_r <= tw_rd_r ? rsof_pkg::TW_IDLE : rsof_pkg::TW_RECV;
               end
               tw_cnt_r <= 3'h0;
               tw_got8_r <= 1'b0;
            end
            rsof_pkg::TW_SEND:
            begin
               if (tw_got8_r)
               begin
                  sda_low_r <= 1'b0; // let the master answer
                  tw_got8_r <= 1'b0;
                  tw_r <= rsof_pkg::TW_MACK;
               end
               else
               begin
                  sda_low_r <= !tw_sh_r[7];
                  tw_sh_r <= {tw_sh_r[6:0], 1'b0};
               end
            end
            default: sda_low_r <= 1'b0;
         endcase
      end
   end

   // pin drivers, all registered; pins shared between the two modes
   always_ff @(posedge CLK)
   begin
      if (SYS_RST)
      begin
         TXD_SCL_O <= 1'b1;
         TXD_SCL_OE <= 1'b0;
         RXD_SDA_O <= 1'b0;
         RXD_SDA_OE <= 1'b0;
         FRAME_BUSY <= 1'b0;
      end
      else
      begin
         TXD_SCL_O <= IF_TWI ? 1'b0 : tx_sh_r[0]; // [RQ14]
         TXD_SCL_OE <= !IF_TWI; // no clock stretching [RQ10]
         RXD_SDA_O <= 1'b0; // open drain, only ever low
         RXD_SDA_OE <= IF_TWI && sda_low_r; // [RQ14]
         FRAME_BUSY <= gen_act_r || pop_if.valid || (tx_bits_r != 4'h0);
      end
   end
endmodule : rsof_top
`default_nettype wire

// >>> verif/rsof_host_model.sv
`default_nettype none
module rsof_host_model #(
   parameter int unsigned BAUD_CYCLES = 4,
   parameter int HALF = 13 // scl half period, about 385 kHz
) (
   input wire logic clk,
   input wire logic tx_o,
   input wire logic tx_oe,
   input wire logic sda_oe,
   output logic scl,
   output logic sda
);
   timeunit 1ns;
   timeprecision 1ns;
   logic scl_r = 1'h1; // high = clock released
   logic pull_r = 1'h0; // high = host pulls data low
   logic [7:0] rx_q[$]; // serial bytes in arrival order
   logic [7:0] twi_q[$]; // bus bytes in arrival order
   int stop_bad = 0; // stop bits seen low
   // pulled-up wires; the device owns the clock pin in serial mode
   assign scl = tx_oe ? tx_o : scl_r;
   assign sda = !(sda_oe || pull_r);
   // serial receiver, mid-bit sampling on the falling clock
   initial
   begin : rx_loop
      logic [7:0] b;
      forever
      begin
         @(negedge clk);
         if (tx_oe && scl === 1'h0)
         begin
            repeat (BAUD_CYCLES / 2) @(negedge clk);
            for (int i = 0; i < 8; i++)
            begin
               repeat (BAUD_CYCLES) @(negedge clk);
               b[i] = scl;
            end
            repeat (BAUD_CYCLES) @(negedge clk);
            if (scl !== 1'h1)
               stop_bad++;
            rx_q.push_back(b);
         end
      end
   end
   task automatic tick(input int n);
      repeat (n) @(negedge clk);
   endtask : tick
   // master bit: data moves mid-low
   task automatic put_bit(input logic b);
      tick(HALF / 2);
      pull_r = !b;
      tick(HALF - HALF / 2);
      scl_r = 1'h1;
      tick(HALF);
      scl_r = 1'h0;
   endtask : put_bit
   // released data, sampled mid-high
   task automatic get_bit(output logic b);
      tick(HALF / 2);
      pull_r = 1'h0;
      tick(HALF - HALF / 2);
      scl_r = 1'h1;
      tick(HALF / 2);
      b = sda;
      tick(HALF - HALF / 2);
      scl_r = 1'h0;
   endtask : get_bit
   // read only, never a command first, so no wait is owed
   task automatic twi_read(input logic [6:0] addr, input int n, output logic nak);
      logic [7:0] b;
      pull_r = 1'h1; // start
      tick(HALF);
      scl_r = 1'h0;
      for (int i = 6; i >= 0; i--)
         put_bit(addr[i]);
      put_bit(1'h1);
      get_bit(nak);
      for (int k = 0; k < n && nak === 1'h0; k++)
      begin
         for (int j = 7; j >= 0; j--)
            get_bit(b[j]);
         twi_q.push_back(b);
         put_bit(k == n - 1);
      end
      tick(HALF / 2);
      pull_r = 1'h1; // stop
      tick(HALF / 2);
      scl_r = 1'h1;
      tick(HALF);
      pull_r = 1'h0;
      tick(HALF);
   endtask : twi_read
endmodule : rsof_host_model
`default_nettype wire

// >>> verif/rsof_top_chk.sv
`default_nettype none
module rsof_top_chk #(
   parameter int unsigned BAUD_CYCLES = 4
) (
   input wire logic CLK,
   input wire logic SYS_RST,
   input wire logic MEAS_VALID,
   input wire logic IF_TWI,
   input wire logic RXD_SDA_O,
   input wire logic RXD_SDA_OE,
   input wire logic TXD_SCL_I,
   input wire logic TXD_SCL_O,
   input wire logic TXD_SCL_OE,
   input wire logic FRAME_BUSY,
   input wire logic MEAS_DROP
);
   timeunit 1ns;
   timeprecision 1ns;
   logic last_r; // serial level one cycle back
   logic [15:0] run_r; // cycles since the level changed, saturating
   // run length of the line, so a short bit cannot hide
   always_ff @(posedge CLK)
   begin
      last_r <= TXD_SCL_O;
      if (SYS_RST)
         run_r <= 16'hFFFF;
      else if (TXD_SCL_O != last_r)
         run_r <= 16'h0001;
      else if (run_r != 16'hFFFF)
         run_r <= run_r + 16'h0001;
   end
   default clocking cb @(posedge CLK);
   endclocking
   default disable iff (SYS_RST);
   // a capture with the serial side idle and settled
   sequence s_go;
      !IF_TWI && !$past(IF_TWI) && !$past(SYS_RST) && MEAS_VALID && !FRAME_BUSY;
   endsequence
   property p_rst;
      disable iff (1'h0) SYS_RST |=> TXD_SCL_O && !TXD_SCL_OE && !RXD_SDA_OE && !FRAME_BUSY;
   endproperty
   a_rst: assert property (p_rst) else $error("outputs not at rest in reset");
   property p_oe;
      !SYS_RST |=> TXD_SCL_OE == !$past(IF_TWI);
   endproperty
   a_oe: assert property (p_oe) else $error("clock pin enable wrong");
   property p_sda_o;
      RXD_SDA_O == 1'h0;
   endproperty
   a_sda_o: assert property (p_sda_o) else $error("data pin driven high");
   property p_sda_uart;
      !IF_TWI && !$past(IF_TWI) |-> !RXD_SDA_OE;
   endproperty
   a_sda_uart: assert property (p_sda_uart) else $error("data pin driven in serial mode");
   property p_scl_twi;
      !$past(SYS_RST) && IF_TWI && $past(IF_TWI) |-> !TXD_SCL_O;
   endproperty
   a_scl_twi: assert property (p_scl_twi) else $error("clock pin level in bus mode");
   property p_drop;
      MEAS_DROP |-> $past(MEAS_VALID) && !$past(IF_TWI);
   endproperty
   a_drop: assert property (p_drop) else $error("drop without a refused capture");
   property p_start;
      s_go |-> ##[2:12] !TXD_SCL_O;
   endproperty
   a_start: assert property (p_start) else $error("no start bit after capture");
   property p_busy;
      s_go |-> ##[1:2] FRAME_BUSY;
   endproperty
   a_busy: assert property (p_busy) else $error("busy did not rise");
   property p_bit;
      !IF_TWI && !$past(IF_TWI) && TXD_SCL_O != last_r |-> run_r >= BAUD_CYCLES;
   endproperty
   a_bit: assert property (p_bit) else $error("serial bit too short");
   property p_sda_chg;
      IF_TWI && $past(IF_TWI) && RXD_SDA_OE != $past(RXD_SDA_OE) |-> !TXD_SCL_I;
   endproperty
   a_sda_chg: assert property (p_sda_chg) else $error("data moved with clock high");
   c_busy: cover property ($rose(FRAME_BUSY));
   c_drop: cover property (MEAS_DROP);
   c_drive: cover property ($rose(RXD_SDA_OE));
endmodule : rsof_top_chk
bind rsof_top rsof_top_chk #(.BAUD_CYCLES(BAUD_CYCLES)) i_chk (.CLK(CLK), .SYS_RST(SYS_RST),
   .MEAS_VALID(MEAS_VALID), .IF_TWI(IF_TWI), .RXD_SDA_O(RXD_SDA_O), .RXD_SDA_OE(RXD_SDA_OE),
   .TXD_SCL_I(TXD_SCL_I), .TXD_SCL_O(TXD_SCL_O), .TXD_SCL_OE(TXD_SCL_OE),
   .FRAME_BUSY(FRAME_BUSY), .MEAS_DROP(MEAS_DROP));
`default_nettype wire

// >>> verif/rsof_top_tb_top.sv
`default_nettype none
module rsof_top_tb_top;
   timeunit 1ns;
   timeprecision 1ns;
   localparam int unsigned BC = 4; // short serial bit keeps the run brief
   logic clk = 1'h0;
   logic sys_rst = 1'h1;
   logic meas_valid = 1'h0;
   logic [15:0] meas_dist = 16'h0000;
   logic [15:0] meas_strength = 16'h0000;
   logic [15:0] meas_temp = 16'h0000;
   logic fmt_string = 1'h0;
   logic if_twi = 1'h0;
   logic [6:0] twi_addr = 7'h00;
   wire logic scl_w;
   wire logic sda_w;
   logic sda_o, sda_oe, scl_o, scl_oe, busy, drop, nak, dr;
   int bad_count = 0;
   int compares = 0;
   int cycles = 0;
   int dists[4] = '{121, 5, 65535, 1000}; // boundaries of the metre text
   logic [7:0] exp_q[$];
   rsof_top #(.BAUD_CYCLES(BC)) i_dut (
      .CLK(clk), .SYS_RST(sys_rst), .MEAS_VALID(meas_valid), .MEAS_DIST(meas_dist),
      .MEAS_STRENGTH(meas_strength), .MEAS_TEMP(meas_temp), .FMT_STRING(fmt_string),
      .IF_TWI(if_twi), .TWI_ADDR(twi_addr), .RXD_SDA_I(sda_w), .RXD_SDA_O(sda_o),
      .RXD_SDA_OE(sda_oe), .TXD_SCL_I(scl_w), .TXD_SCL_O(scl_o), .TXD_SCL_OE(scl_oe),
      .FRAME_BUSY(busy), .MEAS_DROP(drop));
   rsof_host_model #(.BAUD_CYCLES(BC)) i_host (
      .clk(clk), .tx_o(scl_o), .tx_oe(scl_oe), .sda_oe(sda_oe), .scl(scl_w), .sda(sda_w));
   initial
   begin
      forever #50 clk = ~clk;
   end
   // hang guard
   always @(posedge clk)
   begin
      cycles <= cycles + 1;
      if (cycles == 30000)
      begin
         bad_count++;
         wrap_up();
      end
   end
   task automatic wrap_up();
      $display("compares %0d bad_count %0d", compares, bad_count);
      if (bad_count == 0 && compares > 0)
         $display("SIMULATION PASSED");
      else
         $display("SIMULATION FAILED");
      $finish;
   endtask : wrap_up
   task automatic check(input string what, input logic [7:0] exp, input logic [7:0] got);
      compares++;
      if (got !== exp)
      begin
         bad_count++;
         $display("BAD %s expected %h seen %h", what, exp, got);
      end
   endtask : check
   // one-cycle capture pulse; dr notes a refusal
   task automatic measure(input logic [15:0] d, s, t);
      @(negedge clk);
      meas_valid = 1'h1;
      meas_dist = d;
      meas_strength = s;
      meas_temp = t;
      @(negedge clk);
      meas_valid = 1'h0;
      dr = drop;
      @(negedge clk);
      dr = dr | drop;
   endtask : measure
   function automatic void exp_bin(input logic [15:0] d, s, t);
      logic [7:0] sum;
      exp_q = '{8'h59, 8'h59, d[7:0], d[15:8], s[7:0], s[15:8], t[7:0], t[15:8]};
      sum = 8'h00;
      foreach (exp_q[i])
         sum += exp_q[i];
      exp_q.push_back(sum);
   endfunction : exp_bin
   // metres with two decimals, leading zeros dropped
   function automatic void exp_str(input int d);
      exp_q = {};
      if (d >= 10000)
         exp_q.push_back(8'h30 + 8'(d / 10000));
      if (d >= 1000)
         exp_q.push_back(8'h30 + 8'(d / 1000 % 10));
      exp_q.push_back(8'h30 + 8'(d / 100 % 10));
      exp_q.push_back(8'h2E);
      exp_q.push_back(8'h30 + 8'(d / 10 % 10));
      exp_q.push_back(8'h30 + 8'(d % 10));
      exp_q.push_back(8'h0D);
      exp_q.push_back(8'h0A);
   endfunction : exp_str
   // extra bytes stay queued and spoil the next count
   task automatic expect_q(input string what, ref logic [7:0] q[$]);
      for (int w = 0; w < 3000 && q.size() < exp_q.size(); w++)
         @(negedge clk);
      check({what, " count"}, 8'(exp_q.size()), 8'(q.size()));
      while (q.size() > 0 && exp_q.size() > 0)
         check(what, exp_q.pop_front(), q.pop_front());
   endtask : expect_q
   task automatic wait_idle();
      for (int w = 0; w < 3000 && busy !== 1'h0; w++)
         @(negedge clk);
      check("idle", 8'h00, {7'h00, busy});
   endtask : wait_idle
   initial
   begin
      repeat (12) @(negedge clk);
      sys_rst = 1'h0;
      @(negedge clk);
      check("rest pins", 8'h0C, {3'h0, sda_o, scl_o, scl_oe, sda_oe, busy});
      exp_bin(16'h1234, 16'hFFFF, 16'h0A28);
      measure(16'h1234, 16'hFFFF, 16'h0A28);
      check("first drop", 8'h00, {7'h00, dr});
      measure(16'h4321, 16'h0000, 16'h0000);
      check("busy drop", 8'h01, {7'h00, dr});
      expect_q("binary", i_host.rx_q);
      wait_idle();
      fmt_string = 1'h1;
      foreach (dists[i])
      begin
         exp_str(dists[i]);
         measure(16'(dists[i]), 16'h0000, 16'h0000);
         expect_q("string", i_host.rx_q);
         wait_idle();
      end
      fmt_string = 1'h0;
      exp_bin(16'hFFFF, 16'h0000, 16'hFFFF);
      measure(16'hFFFF, 16'h0000, 16'hFFFF);
      expect_q("binary back", i_host.rx_q);
      wait_idle();
      check("stop bits", 8'h00, 8'(i_host.stop_bad));
      if_twi = 1'h1;
      repeat (3) @(negedge clk);
      check("clock pin free", 8'h00, {6'h00, scl_oe, scl_o});
      exp_bin(16'h0102, 16'h0304, 16'h0506);
      measure(16'h0102, 16'h0304, 16'h0506);
      i_host.twi_read(7'h11, 1, nak);
      check("foreign addr", 8'h01, {7'h00, nak});
      i_host.twi_read(7'h10, 10, nak);
      check("default addr", 8'h00, {7'h00, nak});
      exp_q.push_back(8'h59);
      expect_q("bus frame", i_host.twi_q);
      twi_addr = 7'h7F;
      i_host.twi_read(7'h10, 1, nak);
      check("old addr", 8'h01, {7'h00, nak});
      i_host.twi_read(7'h7F, 2, nak);
      exp_q = '{8'h59, 8'h59};
      expect_q("top addr", i_host.twi_q);
      wrap_up();
   end
endmodule : rsof_top_tb_top
`default_nettype wire
